// ### hdl/abs_dec_if.sv
// Purpose : carries a decoded instruction from decoder to execute logic
// Assumes : abs_pkg compiled first
// Notes   : purely combinational fields
interface abs_dec_if;
  import abs_pkg::*;

  abs_op_t                  op;
  logic [ADDR_W-1:0]        f_addr;
  logic                     dest_file;
  logic [BIT_W-1:0]         bit_sel;
  logic [DATA_W-1:0]        literal;

  modport dec (output op, f_addr, dest_file, bit_sel, literal);
  modport exe (input  op, f_addr, dest_file, bit_sel, literal);
endinterface

// ### hdl/abs_decoder.sv
// Purpose : decodes the four supported instruction words
// Assumes : instruction word is stable while insn_valid_in is high
// Notes   : unsupported words decode to no operation
module abs_decoder
  import abs_pkg::*;
(
  // instruction
  input  wire logic [abs_pkg::INSN_W-1:0] insn_in,
  input  wire logic                       insn_valid_in,
  // decoded fields
  abs_dec_if.dec                          dec
);

  // ---------------------------------------------------------------
  // field extraction and opcode match
  // ---------------------------------------------------------------
  always_comb begin
    dec.f_addr    = insn_in[F_LSB +: ADDR_W];
    dec.dest_file = insn_in[D_POS];
    dec.bit_sel   = insn_in[B_LSB +: BIT_W];
    dec.literal   = insn_in[K_LSB +: DATA_W];
    dec.op        = ABS_OP_NONE;
    if (insn_valid_in) begin
      if ((insn_in & AND_FILE_MASK) == AND_FILE_PAT) begin
        dec.op = ABS_OP_AND_W_WITH_FILE;
      end else if ((insn_in & AND_LIT_MASK) == AND_LIT_PAT) begin
        dec.op = ABS_OP_AND_LITERAL_WITH_W;
      end else if ((insn_in & BIT_OP_MASK) == BIT_CLR_PAT) begin
        dec.op = ABS_OP_BIT_CLEAR_FILE;
      end else if ((insn_in & BIT_OP_MASK) == BIT_SET_PAT) begin
        dec.op = ABS_OP_BIT_SET_FILE;
      end
    end
  end

endmodule

// ### hdl/abs_exec.sv
// Purpose : executes logical AND and bit set/clear instructions
// Assumes : file register read is combinational, write happens one cycle later
// Notes   : one instruction per cycle, no skip, no flush
// Notes   : every result shows one edge after its word is taken
module abs_exec
  import abs_pkg::*;
(
  // clock and reset
  input  wire logic                       ref_clk_in,
  input  wire logic                       resetn_in,
  // instruction
  input  wire logic [abs_pkg::INSN_W-1:0] insn_in,
  input  wire logic                       insn_valid_in,
  // file register read
  output logic      [abs_pkg::ADDR_W-1:0] file_raddr_out,
  input  wire logic [abs_pkg::DATA_W-1:0] file_rdata_in,
  input  wire logic [abs_pkg::DATA_W-1:0] porta_pins_in,
  input  wire logic [abs_pkg::DATA_W-1:0] portb_pins_in,
  input  wire logic                       prescaler_on_timer_in,
  // file register write
  output logic                            file_we_out,
  output logic      [abs_pkg::ADDR_W-1:0] file_waddr_out,
  output logic      [abs_pkg::DATA_W-1:0] file_wdata_out,
  output logic                            prescaler_clr_out,
  // working register and status
  output logic      [abs_pkg::DATA_W-1:0] w_out,
  output logic                            zero_we_out,
  output logic                            zero_out,
  output logic                            done_out
);
  import abs_pkg::*;

  abs_dec_if dec_bus ();

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  abs_decoder u_dec (
    .insn_in       (insn_in),
    .insn_valid_in (insn_valid_in),
    .dec           (dec_bus)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [DATA_W-1:0] bit_mask(input logic [BIT_W-1:0] b);
    bit_mask = BIT_ONE << b;
  endfunction

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == DATA_ZERO);
  endfunction

  // timer register address, a write there restarts the prescaler when it is assigned to the timer
  function automatic logic is_timer(input logic [ADDR_W-1:0] a);
    is_timer = (a == TIMER_ADDR);
  endfunction

  // ---------------------------------------------------------------
  // state and datapath signals
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] w_q;            // working register
  logic [DATA_W-1:0] operand;        // file value after pin substitution
  logic [DATA_W-1:0] result;         // alu output
  logic              wr_file;        // result goes to the file register
  logic              wr_w;           // result goes to the working register
  logic              set_zero;       // zero flag follows this result
  logic              file_we_q;
  logic [ADDR_W-1:0] file_waddr_q;
  logic [DATA_W-1:0] file_wdata_q;
  logic              presc_clr_q;
  logic              zero_we_q;
  logic              zero_q;
  logic              done_q;

  // read address straight from the f field, read path is combinational
  assign file_raddr_out = dec_bus.f_addr;

  // ---------------------------------------------------------------
  // operand select: ports read from pins
  // ---------------------------------------------------------------
  always_comb begin
    if (dec_bus.f_addr == PORTA_ADDR) begin
      operand = porta_pins_in;
    end else if (dec_bus.f_addr == PORTB_ADDR) begin
      operand = portb_pins_in;
    end else begin
      operand = file_rdata_in;
    end
  end

  // ---------------------------------------------------------------
  // alu and destination
  // ---------------------------------------------------------------
  always_comb begin
    result   = DATA_ZERO;
    wr_file  = 1'b0;
    wr_w     = 1'b0;
    set_zero = 1'b0;
    case (dec_bus.op)
      ABS_OP_AND_W_WITH_FILE: begin
        result   = w_q & operand;
        set_zero = 1'b1;
        wr_file  = dec_bus.dest_file;
        wr_w     = ~dec_bus.dest_file;
      end
      ABS_OP_AND_LITERAL_WITH_W: begin
        result   = w_q & dec_bus.literal;
        set_zero = 1'b1;
        wr_w     = 1'b1;
      end
      ABS_OP_BIT_CLEAR_FILE: begin
        result   = operand & ~bit_mask(dec_bus.bit_sel);
        wr_file  = 1'b1;
      end
      ABS_OP_BIT_SET_FILE: begin
        result   = operand | bit_mask(dec_bus.bit_sel);
        wr_file  = 1'b1;
      end
      default: begin
        result   = DATA_ZERO;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // working register
  // ---------------------------------------------------------------
  // only the and operations with W as target reach it
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      w_q <= W_RESET;
    end else if (wr_w) begin
      w_q <= result;
    end
  end
  assign w_out = w_q;

  // ---------------------------------------------------------------
  // file write port
  // ---------------------------------------------------------------
  // write strobe, one pulse per file destination
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      file_we_q <= 1'b0;
    end else begin
      file_we_q <= wr_file;
    end
  end

  // write address and data, meaningful only with the strobe
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      file_waddr_q <= '0;
      file_wdata_q <= DATA_ZERO;
    end else begin
      file_waddr_q <= dec_bus.f_addr;
      file_wdata_q <= result;
    end
  end

  assign file_we_out    = file_we_q;
  assign file_waddr_out = file_waddr_q;
  assign file_wdata_out = file_wdata_q;

  // ---------------------------------------------------------------
  // prescaler clear
  // ---------------------------------------------------------------
  // any file write to the timer restarts an assigned prescaler
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      presc_clr_q <= 1'b0;
    end else begin
      presc_clr_q <= wr_file && is_timer(dec_bus.f_addr)
                     && prescaler_on_timer_in;
    end
  end
  assign prescaler_clr_out = presc_clr_q;

  // ---------------------------------------------------------------
  // zero flag
  // ---------------------------------------------------------------
  // update strobe, the status datapath owns the flag itself
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      zero_we_q <= 1'b0;
    end else begin
      zero_we_q <= set_zero;
    end
  end

  // flag value, held between and operations
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      zero_q <= 1'b0;
    end else if (set_zero) begin
      zero_q <= is_zero(result);
    end
  end

  assign zero_we_out = zero_we_q;
  assign zero_out    = zero_q;

  // ---------------------------------------------------------------
  // completion
  // ---------------------------------------------------------------
  // one pulse per executed word, never a skip or flush
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (dec_bus.op != ABS_OP_NONE);
    end
  end
  assign done_out = done_q;

endmodule

// ### hdl/abs_pkg.sv
// Purpose : constants and types for the logic and bit set/clear execute block
// Assumes : 12-bit instruction word, 8-bit data path, 32 file registers
// Notes   : all encodings and addresses used by the block live here
package abs_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int BIT_W  = 3;

  // ---------------------------------------------------------------
  // opcode patterns and masks
  // ---------------------------------------------------------------
  localparam logic [INSN_W-1:0] AND_FILE_MASK  = 12'h0fc0;
  localparam logic [INSN_W-1:0] AND_FILE_PAT   = 12'h0140;
  localparam logic [INSN_W-1:0] AND_LIT_MASK   = 12'h0f00;
  localparam logic [INSN_W-1:0] AND_LIT_PAT    = 12'h0e00;
  localparam logic [INSN_W-1:0] BIT_OP_MASK    = 12'h0f00;
  localparam logic [INSN_W-1:0] BIT_CLR_PAT    = 12'h0400;
  localparam logic [INSN_W-1:0] BIT_SET_PAT    = 12'h0500;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int F_LSB    = 0;
  localparam int D_POS    = 5;
  localparam int B_LSB    = 5;
  localparam int K_LSB    = 0;

  // ---------------------------------------------------------------
  // special file addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] TIMER_ADDR  = 5'h01;
  localparam logic [ADDR_W-1:0] PORTA_ADDR  = 5'h05;
  localparam logic [ADDR_W-1:0] PORTB_ADDR  = 5'h06;
  localparam logic [DATA_W-1:0] W_RESET     = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
  localparam logic [DATA_W-1:0] BIT_ONE     = 8'h01;

  // ---------------------------------------------------------------
  // decoded operation
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ABS_OP_NONE,
    ABS_OP_AND_W_WITH_FILE,
    ABS_OP_AND_LITERAL_WITH_W,
    ABS_OP_BIT_CLEAR_FILE,
    ABS_OP_BIT_SET_FILE
  } abs_op_t;

endpackage

// ### test/abs_exec_properties.sv
// Purpose : concurrent checks on the execute block ports
// Assumes : result of a taken word shows one edge later
// Notes   : port operands (f 5, 6) checked apart from plain files
module abs_exec_properties
  import abs_pkg::*;
(
  // clock, reset, instruction
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic [11:0] insn_in,
  input wire logic        insn_valid_in,
  // operands
  input wire logic [7:0]  file_rdata_in,
  input wire logic [7:0]  porta_pins_in,
  input wire logic [7:0]  portb_pins_in,
  input wire logic        prescaler_on_timer_in,
  // results
  input wire logic        file_we_out,
  input wire logic [4:0]  file_waddr_out,
  input wire logic [7:0]  file_wdata_out,
  input wire logic        prescaler_clr_out,
  input wire logic [7:0]  w_out,
  input wire logic        zero_we_out,
  input wire logic        zero_out,
  input wire logic        done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // decode of the taken word
  wire       and_f = insn_valid_in && insn_in[11:6] == 6'h05;
  wire       and_l = insn_valid_in && insn_in[11:8] == 4'he;
  wire       b_clr = insn_valid_in && insn_in[11:8] == 4'h4;
  wire       b_set = insn_valid_in && insn_in[11:8] == 4'h5;
  wire       any   = and_f || and_l || b_clr || b_set;
  wire       plain = insn_in[4:0] != PORTA_ADDR && insn_in[4:0] != PORTB_ADDR;
  wire [7:0] mask  = 8'h01 << insn_in[7:5];
  // write strobe aimed at the decoded file address
  sequence s_file_wr;
    file_we_out && file_waddr_out == $past(insn_in[4:0]);
  endsequence
  a_and_lit_w: assert property (and_l |=> w_out == $past(w_out & insn_in[7:0])
    && zero_we_out && zero_out == (w_out == 8'h00)) else $error("and literal wrong");
  a_and_file_w: assert property (and_f && !insn_in[5] && plain |=>
    w_out == $past(w_out & file_rdata_in) && !file_we_out && zero_we_out) else $error("and to w wrong");
  a_and_file_f: assert property (and_f && insn_in[5] && plain |=> s_file_wr ##0
    (file_wdata_out == $past(w_out & file_rdata_in) && $stable(w_out))) else $error("and to file wrong");
  a_bit_clear: assert property (b_clr && plain |=> s_file_wr ##0
    (file_wdata_out == $past(file_rdata_in & ~mask) && !zero_we_out)) else $error("bit clear wrong");
  a_bit_set: assert property (b_set && plain |=> s_file_wr ##0
    (file_wdata_out == $past(file_rdata_in | mask) && !zero_we_out)) else $error("bit set wrong");
  a_one_cycle: assert property (any |=> done_out) else $error("done missing");
  a_no_work: assert property (!any |=> !done_out && !file_we_out && !zero_we_out)
    else $error("stray result");
  a_port_pins: assert property (b_set && !plain |=>
    file_wdata_out == $past((insn_in[0] ? porta_pins_in : portb_pins_in) | mask)) else $error("pin operand wrong");
  a_presc_clr: assert property ((b_clr || b_set || and_f && insn_in[5]) && insn_in[4:0] == TIMER_ADDR
    |=> prescaler_clr_out == $past(prescaler_on_timer_in)) else $error("prescaler clear wrong");
endmodule
bind abs_exec abs_exec_properties abs_exec_properties_i (
  .ref_clk_in            (ref_clk_in),
  .resetn_in             (resetn_in),
  .insn_in               (insn_in),
  .insn_valid_in         (insn_valid_in),
  .file_rdata_in         (file_rdata_in),
  .porta_pins_in         (porta_pins_in),
  .portb_pins_in         (portb_pins_in),
  .prescaler_on_timer_in (prescaler_on_timer_in),
  .file_we_out           (file_we_out),
  .file_waddr_out        (file_waddr_out),
  .file_wdata_out        (file_wdata_out),
  .prescaler_clr_out     (prescaler_clr_out),
  .w_out                 (w_out),
  .zero_we_out           (zero_we_out),
  .zero_out              (zero_out),
  .done_out              (done_out)
);

// ### test/and_and_bit_set_clear_ops_test.sv
// Purpose : self-checking bench for the execute block
// Assumes : one word per step, its result one edge later
// Notes   : W resets to zero and only AND ops reach it
module and_and_bit_set_clear_ops_test;
  timeunit 1ns;
  timeprecision 1ns;
  import abs_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [11:0] insn_in = 12'h000;
  logic        insn_valid_in = 1'b0;
  logic [7:0]  file_rdata_in = 8'h00, porta_pins_in = 8'h0f, portb_pins_in = 8'h3c;
  logic        prescaler_on_timer_in = 1'b0;
  logic        file_we_out, prescaler_clr_out, zero_we_out, zero_out, done_out;
  logic [4:0]  file_raddr_out, file_waddr_out;
  logic [7:0]  file_wdata_out, w_out;
  int          error_cnt = 0, n_compared = 0;
  abs_exec abs_exec_i (
    .ref_clk_in            (ref_clk_in),
    .resetn_in             (resetn_in),
    .insn_in               (insn_in),
    .insn_valid_in         (insn_valid_in),
    .file_raddr_out        (file_raddr_out),
    .file_rdata_in         (file_rdata_in),
    .porta_pins_in         (porta_pins_in),
    .portb_pins_in         (portb_pins_in),
    .prescaler_on_timer_in (prescaler_on_timer_in),
    .file_we_out           (file_we_out),
    .file_waddr_out        (file_waddr_out),
    .file_wdata_out        (file_wdata_out),
    .prescaler_clr_out     (prescaler_clr_out),
    .w_out                 (w_out),
    .zero_we_out           (zero_we_out),
    .zero_out              (zero_out),
    .done_out              (done_out)
  );
  initial forever #10 ref_clk_in = ~ref_clk_in;
  // compare and count
  task automatic chk(input logic [7:0] seen, exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // one word for one cycle, then look after the answering edge
  task automatic step(input logic [11:0] i, input logic [7:0] rd);
    @(posedge ref_clk_in);
    insn_in <= i;
    insn_valid_in <= 1'b1;
    file_rdata_in <= rd;
    @(posedge ref_clk_in);
    insn_valid_in <= 1'b0;
    #1;
  endtask
  task automatic t_and();
    step(12'he5f, 8'h00);
    chk(w_out, 8'h00, "lit w");
    chk(zero_we_out, 1'b1, "lit flag");
    chk(done_out, 1'b1, "lit done");
    step(12'h143, 8'hc2);
    chk(file_we_out, 1'b0, "d0 write");
    chk(zero_out, 1'b1, "d0 zero");
    step(12'h163, 8'hc2);
    chk(file_we_out, 1'b1, "d1 write");
    chk(file_wdata_out, 8'h00, "d1 data");
    step(12'h1c3, 8'hff);
    chk(done_out, 1'b0, "other op done");
    $display("end of and test");
  endtask
  task automatic t_bits();
    for (int b = 0; b < 8; b++) begin
      step(12'h40a | 12'(b << 5), 8'hc7);
      chk(file_wdata_out, 8'hc7 & ~(8'h01 << b), "clear data");
      chk(zero_we_out, 1'b0, "clear flag");
      step(12'h50a | 12'(b << 5), 8'h0a);
      chk(file_wdata_out, 8'h0a | (8'h01 << b), "set data");
      chk(file_waddr_out, 5'h0a, "set addr");
      chk(done_out, 1'b1, "set done");
    end
    $display("end of bit test");
  endtask
  task automatic t_ports();
    step(12'h5e5, 8'hf0);
    chk(file_wdata_out, 8'h8f, "port a pins");
    step(12'h506, 8'hc0);
    chk(file_wdata_out, 8'h3d, "port b pins");
    step(12'h465, 8'hff);
    chk(file_wdata_out, 8'h07, "port a clear");
    @(posedge ref_clk_in);
    prescaler_on_timer_in <= 1'b1;
    step(12'h401, 8'hff);
    chk(prescaler_clr_out, 1'b1, "timer clear");
    step(12'h141, 8'hff);
    chk(prescaler_clr_out, 1'b0, "no timer write");
    step(12'h161, 8'hff);
    chk(prescaler_clr_out, 1'b1, "and to timer");
    @(posedge ref_clk_in);
    prescaler_on_timer_in <= 1'b0;
    step(12'h501, 8'h00);
    chk(prescaler_clr_out, 1'b0, "unassigned");
    $display("end of port and timer test");
  endtask
  // reset in mid-run beats a taken word, the first word after release works
  task automatic t_reset();
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    insn_in <= 12'h5ea;
    insn_valid_in <= 1'b1;
    file_rdata_in <= 8'h00;
    #1;
    chk(file_raddr_out, 5'h0a, "read addr");
    @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    insn_valid_in <= 1'b0;
    #1;
    chk(file_we_out, 1'b0, "reset write");
    chk(done_out, 1'b0, "reset done");
    chk(zero_out, 1'b0, "reset zero");
    step(12'h5ea, 8'h00);
    chk(file_wdata_out, 8'h80, "set after reset");
    chk(zero_out, 1'b0, "zero held");
    $display("end of reset test");
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // bounded run time
  initial begin
    repeat (2000) @(posedge ref_clk_in);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t_and();
    t_bits();
    t_ports();
    t_reset();
    give_verdict();
  end
endmodule
